// ### wsw_pkg.sv
// constants, register map and state type of the watchdog / sleep-wake block
// assumes one 125 MHz core clock and an APB master with 32-bit data
package wsw_pkg;
   // timing
   localparam int CLK_MHZ        = 125;
   localparam int WD_PERIOD_US   = 18000;
   localparam int WD_BASE_CYC    = WD_PERIOD_US * CLK_MHZ;
   localparam int RATIO_LOG_MAX  = 7;

   // register indices; byte address is four times the index
   localparam int ADDR_W         = 16;
   localparam logic [15:0] OPT_IDX  = 16'h0081;
   localparam logic [15:0] CFG_IDX  = 16'h2007;
   localparam logic [15:0] STAT_IDX = 16'h0003;
   localparam logic [15:0] IRQS_IDX = 16'h0010;
   localparam logic [15:0] IRQM_IDX = 16'h0011;

   // timer_prescale_config fields
   localparam logic [7:0] OPT_RESET   = 8'hFF;
   localparam int         OPT_ASSIGN_BIT = 3;
   localparam int         OPT_PS_LSB  = 0;
   localparam int         OPT_PS_W    = 3;

   // device_config_word field
   localparam int CFG_WDEN_BIT = 3;

   // status word fields
   localparam int STAT_TMO_BIT = 4;
   localparam int STAT_PWD_BIT = 3;

   // interrupt events
   localparam int EV_W       = 3;
   localparam int EV_TIMEOUT = 0;
   localparam int EV_WAKE    = 1;
   localparam int EV_SLEEP   = 2;
   localparam logic [EV_W-1:0] IRQ_MASK_RESET = 3'h0;

   localparam int          PC_W        = 13;
   localparam logic [12:0] VECTOR_ADDR = 13'h0004;

   typedef enum logic [1:0] {
      WSW_RUN   = 2'b00,
      WSW_SLEEP = 2'b01
   } wsw_state_t;
endpackage : wsw_pkg

// ### wsw_watchdog_sleep_ctrl.sv
// watchdog timer with prescaler, sleep entry and wake-up control, APB slave
// assumes core strobes and interrupt enables/flags are on core_clk; pins are not
// Function
// [R1] timeout while running resets the device
// [R2] timeout while asleep wakes and continues
// [R3] watchdog keeps counting while core sleeps
// [R4] cleared enable fuse disables watchdog forever
// [R5] nominal 18 ms base timeout period
// [R6] software assigns prescaler up to 1:128
// [R7] clear and sleep instructions clear counters
// [R8] any timeout clears the timeout flag
// [R9] sleep entry: clear watchdog, set flags, hold
// [R10] watchdog reset is internal, pin untouched
// [R11] wake sources; only external reset resets
// [R12] powerdown flag set at power-up, cleared sleeping
// [R13] enabled source wakes regardless of global enable
// [R14] global enable selects resume or vector branch
// [R15] sleep prefetches instruction at pc plus one
// [R16] pending enabled interrupt wakes at once
// [R17] every wake-up clears the watchdog
// [R18] software allows multi-second worst case timeout
// [R19] prescale ratio is two to field power
//
// Our own choice: the APB slave port.
module wsw_watchdog_sleep_ctrl #(
   parameter int WD_BASE_CYC  = wsw_pkg::WD_BASE_CYC,
   parameter int NUM_INT      = 7
) (
   // clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        nrst,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [wsw_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr,
   // pins
   input  wire logic                        externalResetPin_n,
   input  wire logic                        watchdogEnableFuse,
   // core instruction stream
   input  wire logic                        clearWatchdogInstr,
   input  wire logic                        sleepInstr,
   input  wire logic [wsw_pkg::PC_W-1:0]    pc,
   // interrupt logic
   input  wire logic [NUM_INT-1:0]          intSrcEnable,
   input  wire logic [NUM_INT-1:0]          intSrcFlag,
   input  wire logic                        globalIntEnable,
   // core control
   output logic                             coreReset,
   output logic                             oscDriverOff,
   output logic                             ioHold,
   output logic                             prefetchValid,
   output logic [wsw_pkg::PC_W-1:0]         prefetchAddr,
   output logic                             wakeResume,
   output logic                             wakeVector,
   output logic [wsw_pkg::PC_W-1:0]         vectorAddr,
   // status
   output logic                             timeoutStatusFlag,
   output logic                             powerdownStatusFlag,
   output logic                             irq
);
   localparam int CW = $clog2(WD_BASE_CYC);
   localparam logic [CW-1:0] BASE_LAST = CW'(WD_BASE_CYC - 1);

   if (WD_BASE_CYC < 2) begin : g_chk_base
      $error("WD_BASE_CYC must be at least 2");
   end
   if (NUM_INT < 1) begin : g_chk_int
      $error("NUM_INT must be at least 1");
   end

   // synchronisers for pins
   logic extRstMeta_r, extRstSync_r, fuseMeta_r, fuseSync_r;
   logic fuseCaught_r, fuseOn_r;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         extRstMeta_r <= 1'b1;
         extRstSync_r <= 1'b1;
         fuseMeta_r   <= 1'b0;
         fuseSync_r   <= 1'b0;
      end else begin
         extRstMeta_r <= externalResetPin_n;
         extRstSync_r <= extRstMeta_r;
         fuseMeta_r   <= watchdogEnableFuse;
         fuseSync_r   <= fuseMeta_r;
      end
   end

   // nonvolatile enable is taken once after reset release and then frozen
   logic [1:0] fuseWait_r;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fuseWait_r   <= 2'h0;
         fuseCaught_r <= 1'b0;
         fuseOn_r     <= 1'b0;
      end else if (!fuseCaught_r) begin
         fuseWait_r <= fuseWait_r + 2'h1;
         if (fuseWait_r == 2'h2) begin
            fuseCaught_r <= 1'b1;
            fuseOn_r     <= fuseSync_r; // see [R4]
         end
      end
   end

   // apb decode
   localparam int EV_W_L = wsw_pkg::EV_W;
   logic [7:0]      option_r;
   logic [EV_W_L-1:0] irqStat_r, irqMask_r, irqStat_nxt, events;
   logic pready_r, pslverr_r;
   logic [31:0] prdata_r;

   wire [15:0] addrOpt  = {wsw_pkg::OPT_IDX[13:0], 2'b00};
   wire [15:0] addrCfg  = {wsw_pkg::CFG_IDX[13:0], 2'b00};
   wire [15:0] addrStat = {wsw_pkg::STAT_IDX[13:0], 2'b00};
   wire [15:0] addrIrqS = {wsw_pkg::IRQS_IDX[13:0], 2'b00};
   wire [15:0] addrIrqM = {wsw_pkg::IRQM_IDX[13:0], 2'b00};

   wire selOpt  = paddr == addrOpt;
   wire selCfg  = paddr == addrCfg;
   wire selStat = paddr == addrStat;
   wire selIrqS = paddr == addrIrqS;
   wire selIrqM = paddr == addrIrqM;
   wire mapped  = selOpt | selCfg | selStat | selIrqS | selIrqM;
   wire accDone = psel & penable & pready_r;
   // config word and status are read-only; writing them is flagged as an error
   wire wrOk    = accDone & pwrite & (selOpt | selIrqS | selIrqM);
   wire errNow  = ~mapped | (pwrite & (selCfg | selStat));

   logic tmoFlag_r, pwdFlag_r;
   wire [7:0] cfgWord  = 8'(fuseOn_r) << wsw_pkg::CFG_WDEN_BIT;
   wire [7:0] statWord = (8'(tmoFlag_r) << wsw_pkg::STAT_TMO_BIT) | (8'(pwdFlag_r) << wsw_pkg::STAT_PWD_BIT);
   wire [31:0] rdMux = selOpt  ? {24'h000000, option_r} :
                       selCfg  ? {24'h000000, cfgWord} :
                       selStat ? {24'h000000, statWord} :
                       selIrqS ? {29'h00000000, irqStat_r} :
                       selIrqM ? {29'h00000000, irqMask_r} : 32'h00000000;

   // one wait state: ready in the second access cycle
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end else begin
         pready_r  <= psel & penable & ~pready_r;
         pslverr_r <= psel & penable & ~pready_r & errNow;
         prdata_r  <= (psel & ~pready_r & ~pwrite) ? rdMux : 32'h00000000;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         option_r  <= wsw_pkg::OPT_RESET;
         irqMask_r <= wsw_pkg::IRQ_MASK_RESET;
      end else begin
         if (wrOk & selOpt) option_r <= pwdata[7:0]; // see [R6]
         if (wrOk & selIrqM) irqMask_r <= pwdata[EV_W_L-1:0];
      end
   end

   // watchdog counters
   logic [CW-1:0] baseCnt_r;
   logic [6:0]    preCnt_r;
   wsw_pkg::wsw_state_t state_r, state_nxt;

   wire assignWd = option_r[wsw_pkg::OPT_ASSIGN_BIT];
   wire [2:0] psField = option_r[wsw_pkg::OPT_PS_LSB +: wsw_pkg::OPT_PS_W];
   // a ratio change mid-period only takes hold cleanly after the next restart
   wire [6:0] preLimit = assignWd ? 7'((8'h01 << psField) - 8'h01) : 7'h00; // see [R19]
   wire baseEnd  = baseCnt_r == BASE_LAST; // see [R5]
   wire wdExpire = fuseOn_r & baseEnd & (preCnt_r == preLimit); // see [R4]
   wire extRst   = ~extRstSync_r;
   wire running  = state_r == wsw_pkg::WSW_RUN;
   wire asleep   = state_r == wsw_pkg::WSW_SLEEP;
   wire intPending = |(intSrcEnable & intSrcFlag); // see [R13]
   // an expiry in the same cycle as the sleep strobe wins; sleep is dropped
   wire sleepGo  = running & sleepInstr & ~extRst & ~wdExpire;
   wire immWake  = sleepGo & intPending; // see [R16]
   wire wakeIrq  = asleep & intPending & ~extRst;
   wire wakeExp  = asleep & wdExpire & ~extRst; // see [R2]
   wire resumeNow = immWake | wakeIrq | wakeExp; // see [R11]
   // restart covers clear, sleep entry, every wake, pin reset and a running expiry
   wire wdRestart = clearWatchdogInstr | sleepGo | resumeNow | extRst | (running & wdExpire); // see [R7] [R17]

   // counts on every core_clk edge regardless of sleep state
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         baseCnt_r <= '0;
         preCnt_r  <= 7'h00;
      end else if (wdRestart | ~fuseOn_r) begin
         baseCnt_r <= '0;
         preCnt_r  <= 7'h00;
      end else if (baseEnd) begin
         baseCnt_r <= '0;
         preCnt_r  <= (preCnt_r == preLimit) ? 7'h00 : preCnt_r + 7'h01;
      end else begin
         baseCnt_r <= baseCnt_r + CW'(1); // see [R3]
      end
   end

   // sleep state machine
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         wsw_pkg::WSW_RUN: begin
            if (sleepGo & ~immWake) state_nxt = wsw_pkg::WSW_SLEEP;
         end
         wsw_pkg::WSW_SLEEP: begin
            if (resumeNow | extRst) state_nxt = wsw_pkg::WSW_RUN;
         end
         default: state_nxt = wsw_pkg::WSW_RUN;
      endcase
   end

   logic coreReset_r, oscOff_r, ioHold_r, prefValid_r, resume_r, vector_r;
   logic [wsw_pkg::PC_W-1:0] prefAddr_r;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_r     <= wsw_pkg::WSW_RUN;
         coreReset_r <= 1'b0;
         oscOff_r    <= 1'b0;
         ioHold_r    <= 1'b0;
         prefValid_r <= 1'b0;
         prefAddr_r  <= '0;
         resume_r    <= 1'b0;
         vector_r    <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         // internal reset request only; the reset pin is never driven
         coreReset_r <= extRst | (running & wdExpire); // see [R1] [R10]
         oscOff_r    <= state_nxt == wsw_pkg::WSW_SLEEP; // see [R9]
         ioHold_r    <= state_nxt == wsw_pkg::WSW_SLEEP; // see [R9]
         prefValid_r <= sleepGo; // see [R15]
         if (sleepGo) prefAddr_r <= pc + wsw_pkg::PC_W'(1); // see [R15]
         resume_r    <= resumeNow;
         vector_r    <= resumeNow & globalIntEnable; // see [R14]
      end
   end

   // status flags: power-up sets both
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tmoFlag_r <= 1'b1;
         pwdFlag_r <= 1'b1; // see [R12]
      end else if (wdExpire) begin
         tmoFlag_r <= 1'b0; // see [R8]
      end else if (sleepGo) begin
         tmoFlag_r <= 1'b1; // see [R9]
         pwdFlag_r <= 1'b0; // see [R12]
      end else if (clearWatchdogInstr) begin
         tmoFlag_r <= 1'b1;
         pwdFlag_r <= 1'b1;
      end
   end

   // sticky events, write one to clear, set wins
   assign events[wsw_pkg::EV_TIMEOUT] = wdExpire;
   assign events[wsw_pkg::EV_WAKE]    = resumeNow;
   assign events[wsw_pkg::EV_SLEEP]   = sleepGo;
   always_comb begin
      irqStat_nxt = irqStat_r;
      if (wrOk & selIrqS) irqStat_nxt = irqStat_nxt & ~pwdata[EV_W_L-1:0];
      irqStat_nxt = irqStat_nxt | events;
   end

   logic irq_r;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irqStat_r <= '0;
         irq_r     <= 1'b0;
      end else begin
         irqStat_r <= irqStat_nxt;
         irq_r     <= |(irqStat_nxt & irqMask_r);
      end
   end

   assign prdata              = prdata_r;
   assign pready              = pready_r;
   assign pslverr             = pslverr_r;
   assign coreReset           = coreReset_r;
   assign oscDriverOff        = oscOff_r;
   assign ioHold              = ioHold_r;
   assign prefetchValid       = prefValid_r;
   assign prefetchAddr        = prefAddr_r;
   assign wakeResume          = resume_r;
   assign wakeVector          = vector_r;
   assign vectorAddr          = wsw_pkg::VECTOR_ADDR;
   assign timeoutStatusFlag   = tmoFlag_r;
   assign powerdownStatusFlag = pwdFlag_r;
   assign irq                 = irq_r;

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // reference count of cycles since the last restart; an option write mid-period voids the check
   logic [CW+7:0] sinceRestart_r;
   logic          optQuiet_r;
   wire  [CW+7:0] periodLast = ((CW+8)'(WD_BASE_CYC) << (assignWd ? psField : 3'h0)) - (CW+8)'(1);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sinceRestart_r <= '0;
         optQuiet_r     <= 1'b1;
      end else begin
         sinceRestart_r <= (wdRestart | ~fuseOn_r) ? '0 : sinceRestart_r + (CW+8)'(1);
         if (wrOk & selOpt) optQuiet_r <= 1'b0;
         else if (wdRestart) optQuiet_r <= 1'b1;
      end
   end

   sequence s_sleep_entry;
      running && sleepInstr && !extRst && !wdExpire;
   endsequence

   sequence s_sleep_state;
      ##1 (!pwdFlag_r && tmoFlag_r && baseCnt_r == '0 && preCnt_r == 7'h00);
   endsequence

   sequence s_wake_state;
      ##1 (resume_r && running && baseCnt_r == '0 && preCnt_r == 7'h00);
   endsequence

   AST_FUSE_OFF: assert property (!fuseOn_r |-> !wdExpire && baseCnt_r == '0) // see [R4]
      else $error("watchdog active with fuse off");
   AST_FUSE_HOLD: assert property (fuseCaught_r |=> $stable(fuseOn_r)) // see [R4]
      else $error("fuse enable changed after capture");
   AST_RUN_RESET: assert property (running && wdExpire |=> coreReset_r && !resume_r) // see [R1]
      else $error("timeout while running did not reset");
   AST_SLEEP_WAKE: assert property (asleep && wdExpire && !extRst |=> resume_r && !coreReset_r && running) // see [R2]
      else $error("timeout in sleep did not wake");
   AST_TMO_CLEAR: assert property (wdExpire |=> !tmoFlag_r) // see [R8]
      else $error("timeout flag not cleared");
   AST_EVENT_SET: assert property (wdExpire |=> irqStat_r[wsw_pkg::EV_TIMEOUT])
      else $error("timeout event not recorded");
   AST_SLEEP_FLAGS: assert property (s_sleep_entry |-> s_sleep_state) // see [R9]
      else $error("sleep entry flags wrong");
   AST_SLEEP_HOLD: assert property (running && sleepInstr && !extRst && !wdExpire && !intPending |=> oscDriverOff && ioHold) // see [R9]
      else $error("sleep entry did not stop oscillator and hold pins");
   AST_CLR_INSTR: assert property (clearWatchdogInstr |=> baseCnt_r == '0 && preCnt_r == 7'h00) // see [R7]
      else $error("clear instruction did not clear watchdog");
   AST_EXT_EXIT: assert property (asleep && extRst |=> running && coreReset_r && !resume_r) // see [R11]
      else $error("pin reset in sleep handled wrong");
   AST_WAKE_OSC: assert property (resume_r |-> !oscDriverOff && !ioHold) // see [R11]
      else $error("oscillator still off after wake");
   AST_PWD_FALL: assert property ($fell(pwdFlag_r) |-> $past(sleepGo)) // see [R12]
      else $error("powerdown flag cleared without sleep");
   AST_VECTOR: assert property (resumeNow |=> wakeVector == $past(globalIntEnable)) // see [R14]
      else $error("vector branch wrong after wake");
   AST_IMM_WAKE: assert property (s_sleep_entry and intPending |=> resume_r && running) // see [R16]
      else $error("pending interrupt did not wake at once");
   AST_PREFETCH: assert property (s_sleep_entry |=> prefetchValid && prefetchAddr == $past(pc) + 13'h0001) // see [R15]
      else $error("prefetch address wrong");
   AST_WAKE_CLR: assert property (resume_r |-> baseCnt_r == '0 && preCnt_r == 7'h00) // see [R17]
      else $error("watchdog not cleared on wake");
   AST_PREF_HOLD: assert property (!sleepGo |=> prefetchAddr == $past(prefetchAddr)) // see [R15]
      else $error("prefetch address moved without sleep");
   AST_INT_WAKE: assert property (asleep && intPending && !extRst |-> s_wake_state) // see [R13]
      else $error("enabled interrupt did not wake");
   AST_SLEEP_COUNT: assert property (asleep && fuseOn_r && !wdRestart && !baseEnd |=> baseCnt_r == $past(baseCnt_r) + CW'(1)) // see [R3]
      else $error("watchdog stalled in sleep");
   AST_PRESCALE: assert property (wdExpire && optQuiet_r |-> sinceRestart_r == periodLast) // see [R5] [R19]
      else $error("timeout period does not match prescale ratio");
endmodule : wsw_watchdog_sleep_ctrl

// ### watchdog_sleep_wake_control_tb_top.sv
// self-checking bench of the watchdog / sleep-wake block
// assumes the design alone on core_clk, driven over apb and core strobe inputs
`define CHK(nm, ex, sn) begin checksDone++; if ((sn) !== (ex)) begin mismatches++; \
   $display("Error %s expected %0h seen %0h", nm, ex, sn); end end
module watchdog_sleep_wake_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // short base count keeps each unprescaled timeout to 20 cycles
   localparam int          BASE   = 20;
   localparam logic [15:0] A_OPT  = wsw_pkg::OPT_IDX << 2;
   localparam logic [15:0] A_CFG  = wsw_pkg::CFG_IDX << 2;
   localparam logic [15:0] A_STAT = wsw_pkg::STAT_IDX << 2;
   localparam logic [15:0] A_IRQS = wsw_pkg::IRQS_IDX << 2;
   localparam logic [15:0] A_IRQM = wsw_pkg::IRQM_IDX << 2;
   logic        core_clk = 1'b0;
   logic        nrst     = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [15:0] paddr    = 16'h0000;
   logic [31:0] pwdata   = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr;
   logic        extPin_n = 1'b1;
   logic        fuse     = 1'b1;
   logic        clrWd    = 1'b0;
   logic        slp      = 1'b0;
   logic        global_int_enable      = 1'b0;
   logic [12:0] pc       = 13'h0;
   logic [6:0]  intEn    = 7'h0;
   logic [6:0]  intFl    = 7'h0;
   logic [12:0] pfAddr, vecAddr;
   logic        coreReset, oscOff, ioHold, pfValid, wakeRes, wakeVec, tmoFlag, pwdFlag, irq;
   int          mismatches = 0;
   int          checksDone = 0;
   int          n, rstCnt = 0, wakeCnt = 0;
   logic [64:0] notes[$];

   always #4 core_clk = ~core_clk;

   wsw_watchdog_sleep_ctrl #(.WD_BASE_CYC(BASE), .NUM_INT(7)) dut_u (
      .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .externalResetPin_n(extPin_n), .watchdogEnableFuse(fuse), .clearWatchdogInstr(clrWd),
      .sleepInstr(slp), .pc(pc), .intSrcEnable(intEn), .intSrcFlag(intFl),
      .globalIntEnable(global_int_enable), .coreReset(coreReset), .oscDriverOff(oscOff), .ioHold(ioHold),
      .prefetchValid(pfValid), .prefetchAddr(pfAddr), .wakeResume(wakeRes),
      .wakeVector(wakeVec), .vectorAddr(vecAddr), .timeoutStatusFlag(tmoFlag),
      .powerdownStatusFlag(pwdFlag), .irq(irq));

   // watcher: each apb answer is matched against the oldest note {slverr, mask, data}
   always @(posedge core_clk) begin
      logic [64:0] nt;
      if (pready === 1'b1 && notes.size() > 0) begin
         nt = notes.pop_front();
         `CHK("pslverr", nt[64], pslverr)
         `CHK("prdata", nt[31:0], prdata & nt[63:32])
      end
      if (coreReset === 1'b1) rstCnt++;
      if (wakeRes === 1'b1) wakeCnt++;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out

   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic err);
      int k;
      notes.push_back({err, m, w ? 32'h0 : d});
      @(posedge core_clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge core_clk);
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k == 20) begin
         mismatches++;
         close_out();
      end
   endtask : apb

   task automatic strobe(input logic s);
      @(posedge core_clk);
      if (s) slp <= 1'b1;
      else clrWd <= 1'b1;
      @(posedge core_clk);
      slp   <= 1'b0;
      clrWd <= 1'b0;
   endtask : strobe

   // wait for core reset (k=0) or wake (k=1), counting edges into n
   task automatic await(input int k, input int lim);
      for (n = 1; n <= lim; n++) begin
         @(posedge core_clk);
         if ((k == 0 ? coreReset : wakeRes) === 1'b1) return;
      end
      $display("Error wait for event %0d ran out", k);
      mismatches++;
      close_out();
   endtask : await

   task automatic per(input int p);
      `CHK("timeout period", 1'b1, n >= p - 1 && n <= p + 2)
   endtask : per

   task automatic do_reset(input logic f);
      nrst <= 1'b0;
      fuse <= f;
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask : do_reset

   initial begin
      int         ps, r0, w0;
      logic [7:0] opt;
      logic [6:0] b;
      n = $urandom(32'hBBB1);
      do_reset(1'b1);
      `CHK("timeout flag", 1'b1, tmoFlag)
      `CHK("powerdown flag", 1'b1, pwdFlag)
      `CHK("base cycles", 18000 * 125, wsw_pkg::WD_BASE_CYC)
      apb(0, A_OPT, 32'hFF, 32'hFF, 0);
      apb(0, A_CFG, 32'h08, 32'h08, 0);
      apb(0, A_STAT, 32'h18, 32'h18, 0);
      apb(0, A_IRQM, 32'h0, 32'h7, 0);
      apb(0, 16'h0100, 32'h0, 32'hFFFFFFFF, 1);
      apb(1, A_CFG, 32'h0, 32'h0, 1);
      apb(1, A_STAT, 32'h0, 32'h0, 1);
      $display("test registers done");
      for (int i = 0; i < 6; i++) begin
         ps  = (i == 5) ? $urandom % 8 : i - 1;
         opt = (i == 0) ? 8'h00 : 8'h08 | ps[2:0];
         apb(1, A_OPT, {24'h0, opt}, 32'h0, 0);
         apb(0, A_OPT, {24'h0, opt}, 32'hFF, 0);
         strobe(1'b0);
         // bound sized for the longest ratio, the slowest case software must allow for
         await(0, (BASE << 7) + 20);
         per(i == 0 ? BASE : BASE << ps);
         `CHK("timeout flag after expiry", 1'b0, tmoFlag)
         `CHK("powerdown flag after expiry", 1'b1, pwdFlag)
      end
      $display("test prescaler done");
      apb(1, A_OPT, 32'h0, 32'h0, 0);
      r0 = rstCnt;
      repeat (12) begin
         strobe(1'b0);
         repeat (14) @(posedge core_clk);
      end
      `CHK("resets while cleared", r0, rstCnt)
      $display("test clear done");
      // sleep late in a period: the wake must come a full period after sleep
      strobe(1'b0);
      repeat (12) @(posedge core_clk);
      pc <= 13'($urandom);
      r0 = rstCnt;
      strobe(1'b1);
      #1;
      `CHK("prefetch valid", 1'b1, pfValid)
      `CHK("prefetch addr", pc + 13'h0001, pfAddr)
      `CHK("osc off", 1'b1, oscOff)
      `CHK("io hold", 1'b1, ioHold)
      `CHK("powerdown cleared", 1'b0, pwdFlag)
      `CHK("timeout flag set", 1'b1, tmoFlag)
      await(1, BASE + 20);
      per(BASE);
      `CHK("timeout flag after wake", 1'b0, tmoFlag)
      `CHK("osc on", 1'b0, oscOff)
      `CHK("no reset asleep", r0, rstCnt)
      await(0, BASE + 20);
      per(BASE);
      $display("test watchdog wake done");
      apb(1, A_OPT, 32'h0F, 32'h0, 0);
      strobe(1'b0);
      for (int g = 0; g < 2; g++) begin
         b   = 7'h01 << ($urandom % 7);
         global_int_enable <= g[0];
         strobe(1'b1);
         intFl <= b;
         w0 = wakeCnt;
         repeat (10) @(posedge core_clk);
         `CHK("wake without enable", w0, wakeCnt)
         intEn <= b;
         await(1, 10);
         `CHK("vector branch", g[0], wakeVec)
         `CHK("vector addr", 13'h0004, vecAddr)
         strobe(1'b1);
         intEn <= 7'h0;
         intFl <= 7'h0;
         #1;
         `CHK("pending wake", 1'b1, wakeRes)
         `CHK("pending osc", 1'b0, oscOff)
      end
      $display("test interrupt wake done");
      apb(0, A_IRQS, 32'h7, 32'h7, 0);
      `CHK("irq masked", 1'b0, irq)
      apb(1, A_IRQM, 32'h2, 32'h0, 0);
      apb(0, A_IRQM, 32'h2, 32'h7, 0);
      repeat (2) @(posedge core_clk);
      `CHK("irq raised", 1'b1, irq)
      apb(1, A_IRQS, 32'h2, 32'h0, 0);
      repeat (2) @(posedge core_clk);
      `CHK("irq cleared", 1'b0, irq)
      apb(0, A_IRQS, 32'h5, 32'h7, 0);
      $display("test irq done");
      strobe(1'b1);
      r0 = rstCnt;
      w0 = wakeCnt;
      extPin_n <= 1'b0;
      repeat (6) @(posedge core_clk);
      extPin_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      `CHK("pin reset", 1'b1, rstCnt > r0)
      `CHK("no wake on pin", w0, wakeCnt)
      `CHK("osc after pin", 1'b0, oscOff)
      `CHK("powerdown kept", 1'b0, pwdFlag)
      $display("test pin reset done");
      do_reset(1'b0);
      apb(1, A_OPT, 32'h0, 32'h0, 0);
      apb(0, A_CFG, 32'h0, 32'h08, 0);
      r0 = rstCnt;
      repeat (200) @(posedge core_clk);
      `CHK("fuse off resets", r0, rstCnt)
      $display("test fuse off done");
      close_out();
   end
endmodule : watchdog_sleep_wake_control_tb_top
